// File: bench/adc_init_reset_sequencer_test.sv
// Testbench for the sequencer, host and converter ends linked
`include "ais_params.svh"
module adc_init_reset_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL = 50;
  localparam int FUSE = 8;
  logic       clk_sys, rstn, wr, rd, ready, ref_mode;
  logic [7:0] addr, wdata, rdata, cfg, d;
  int         fails, num_checks;
  ais_if lnk ();
  ais_host #(.PWR_WAIT_CYC(20), .WAIT_CYC(64)) ais_host_i (.CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LNK(lnk));
  ais_dev #(.CAL_CYCLES(CAL), .FUSE_CYCLES(FUSE)) ais_dev_i (.CLK_SYS(clk_sys), .RSTN(rstn), .LNK(lnk),
    .READY(ready), .REF_MODE(ref_mode), .CFG(cfg));
  ais_sva #(.CAL_CYCLES(CAL), .FUSE_CYCLES(FUSE)) ais_sva_i (.CLK_SYS(clk_sys), .RSTN(rstn),
    .reset_pin(lnk.reset_pin), .reference_select_pin(lnk.reference_select_pin),
    .sample_clk_en(lnk.sample_clk_en), .serial_port_select(lnk.serial_port_select),
    .ser_addr(lnk.ser_addr), .ser_wdata(lnk.ser_wdata), .READY(ready), .CFG(cfg));
  // ====
  // Bus tasks
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // Polls status; a stale match is avoided by always reading first
  task automatic wait_st(input logic [7:0] e);
    rd_reg(`AIS_HOST_STAT);
    for (int i = 0; i < 400 && d !== e; i++) rd_reg(`AIS_HOST_STAT);
    chk("status", e, d);
  endtask
  task automatic ser(input logic [7:0] a, input logic [7:0] v);
    wr_reg(`AIS_HOST_WADDR, a);
    wr_reg(`AIS_HOST_WDATA, v);
    wr_reg(`AIS_HOST_CTRL, 8'h03);
  endtask
  task automatic summarize();
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ====
  // Clock, watchdog, tests
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    summarize();
  end
  initial begin
    {rstn, wr, rd, addr, wdata, d} = '0;
    fails = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_reg(`AIS_HOST_STAT);
    chk("status", 8'h01, d);
    wr_reg(`AIS_HOST_CTRL, 8'h02);
    wait_st(8'h10);
    chk("ready", 8'h01, {7'h00, ready});
    chk("ref", 8'h01, {7'h00, ref_mode});
    chk("cfg", 8'h00, cfg);
    ser(`AIS_CFG_REG, 8'ha5);
    wait_st(8'h10);
    chk("cfg", 8'ha5, cfg);
    ser(`AIS_SOFT_RESET_CONTROL, 8'h01);
    wait_st(8'h08);
    chk("ready", 8'h00, {7'h00, ready});
    chk("cfg", 8'h00, cfg);
    ser(`AIS_CFG_REG, 8'h77);
    wait_st(8'h10);
    chk("cfg", 8'h00, cfg);
    chk("ready", 8'h01, {7'h00, ready});
    ser(`AIS_CFG_REG, 8'h3c);
    wait_st(8'h10);
    chk("cfg", 8'h3c, cfg);
    // Mid-run reset: reference level falls back to its low default
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    wait_st(8'h10);
    chk("ready", 8'h01, {7'h00, ready});
    chk("ref", 8'h00, {7'h00, ref_mode});
    chk("cfg", 8'h00, cfg);
    summarize();
  end
endmodule

// File: bench/ais_sva.sv
// Checker for the host to converter link
`include "ais_params.svh"
module ais_sva #(
  parameter int CAL_CYCLES  = `AIS_CAL_CYCLES,
  parameter int FUSE_CYCLES = `AIS_FUSE_CYCLES
) (
  // Clock and reset
  input wire logic       CLK_SYS,
  input wire logic       RSTN,
  // Link
  input wire logic       reset_pin,
  input wire logic       reference_select_pin,
  input wire logic       sample_clk_en,
  input wire logic       serial_port_select,
  input wire logic [7:0] ser_addr,
  input wire logic [7:0] ser_wdata,
  // Device status
  input wire logic       READY,
  input wire logic [7:0] CFG
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);
  // ====
  // Pulse and busy counters
  logic [15:0] hi_q;
  logic [17:0] busy_q;
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      hi_q   <= 16'h0000;
      busy_q <= 18'h00000;
    end else begin
      hi_q   <= reset_pin ? hi_q + 16'h0001 : 16'h0000;
      busy_q <= (reset_pin || READY) ? 18'h00000 : busy_q + 18'h00001;
    end
  end
  sequence sel_frame;
    serial_port_select[*3] ##1 !serial_port_select;
  endsequence
  sequence soft_req;
    serial_port_select && READY && ser_addr == 8'h00 && ser_wdata[0];
  endsequence
  // ====
  // Properties
  pulse_width_a: assert property ($fell(reset_pin) |-> hi_q >= 16'h007d)
    else $error("reset pulse too short");
  ref_hold_a: assert property (reset_pin |-> $stable(reference_select_pin))
    else $error("reference pin moved in reset");
  ref_setup_a: assert property ($rose(reset_pin) |->
    reference_select_pin == $past(reference_select_pin, 13))
    else $error("reference setup too short");
  clk_first_a: assert property ($rose(reset_pin) |-> sample_clk_en)
    else $error("reset without sampling clock");
  cal_len_a: assert property ($rose(READY) |->
    busy_q >= CAL_CYCLES && busy_q <= CAL_CYCLES + FUSE_CYCLES + 8)
    else $error("calibration length wrong");
  prog_wait_a: assert property ($rose(serial_port_select) |-> READY)
    else $error("programming before ready");
  sel_shape_a: assert property ($rose(serial_port_select) |-> sel_frame)
    else $error("select frame wrong");
  soft_rst_a: assert property (soft_req |-> ##[1:4] !READY)
    else $error("soft reset not taken");
  cfg_default_a: assert property ($fell(READY) |-> ##[0:4] CFG == 8'h00)
    else $error("defaults not restored");
  ready_hold_a: assert property ($rose(READY) |-> READY[*8])
    else $error("soft reset repeats");
  pin_low_a: assert property (serial_port_select |-> !reset_pin)
    else $error("reset pin high in operation");
  busy_ign_a: assert property (busy_q >= 18'h00010 |=> $stable(CFG))
    else $error("config changed while busy");
endmodule

// File: hdl/ais_dev.sv
// Converter end: fuse load, calibration and soft reset
`include "ais_params.svh"
module ais_dev #(
  parameter int CAL_CYCLES  = `AIS_CAL_CYCLES,
  parameter int FUSE_CYCLES = `AIS_FUSE_CYCLES
) (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RSTN,
  // Link
  ais_if.dev              LNK,
  // Status
  output logic            READY,
  output logic            REF_MODE,
  output logic [7:0]      CFG
);
  // =====================================================
  // State
  typedef struct packed {
    logic [1:0]              rst_sync;
    logic [1:0]              sel_sync;
    logic [1:0]              ref_sync;
    logic [1:0]              clk_sync;
    ais_pkg::ais_dev_state_e st;
    logic [17:0]             cnt;
    logic                    soft_rst;
    logic                    ready;
    logic                    ref_mode;
    ais_pkg::ais_byte_t      cfg;
  } ais_dev_s;
  ais_dev_s s_q, s_d;

  // =====================================================
  // Next state
  always_comb begin
    s_d = s_q;
    // Pins come from another device, so synchronise
    s_d.rst_sync = {s_q.rst_sync[0], LNK.reset_pin};
    s_d.sel_sync = {s_q.sel_sync[0], LNK.serial_port_select};
    s_d.ref_sync = {s_q.ref_sync[0], LNK.reference_select_pin};
    s_d.clk_sync = {s_q.clk_sync[0], LNK.sample_clk_en};
    s_d.soft_rst = 1'b0; // see R10
    case (s_q.st)
      ais_pkg::DV_RESET: begin
        s_d.ready = 1'b0;
        s_d.cnt   = '0;
        if (!s_q.rst_sync[1]) begin
          s_d.st = ais_pkg::DV_FUSE;
        end
      end
      ais_pkg::DV_FUSE: begin
        s_d.cfg = `AIS_CFG_RESET; // see R06
        s_d.ref_mode = s_q.ref_sync[1];
        s_d.cnt = s_q.cnt + 18'h1;
        if (s_q.cnt == 18'(FUSE_CYCLES - 1)) begin
          s_d.cnt = '0;
          s_d.st  = ais_pkg::DV_CAL; // see R06
        end
      end
      ais_pkg::DV_CAL: begin
        // Timed in sampling clocks, so it stalls while none runs
        if (s_q.clk_sync[1]) begin
          s_d.cnt = s_q.cnt + 18'h1;
          if (s_q.cnt == 18'(CAL_CYCLES - 1)) begin
            s_d.st    = ais_pkg::DV_READY; // see R07
            s_d.ready = 1'b1;
          end
        end
      end
      ais_pkg::DV_READY: begin
        // Serial writes only accepted here; earlier ones dropped, see R12
        if (s_q.sel_sync[1]) begin
          if (LNK.ser_addr == `AIS_SOFT_RESET_CONTROL && LNK.ser_wdata[`AIS_SOFT_RESET_BIT]) begin
            s_d.soft_rst = 1'b1; // see R09
            s_d.ready    = 1'b0;
            s_d.cnt      = '0;
            s_d.st       = ais_pkg::DV_FUSE;
          end else if (LNK.ser_addr == `AIS_CFG_REG) begin
            s_d.cfg = LNK.ser_wdata;
          end
        end
      end
      default: s_d.st = ais_pkg::DV_RESET;
    endcase
    // Soft reset pulse clears config in the first fuse-load cycle, together with the fuse reload
    if (s_q.soft_rst) begin
      s_d.cfg = `AIS_CFG_RESET; // see R09
    end
    // Hardware reset pin overrides the next state and the ready flag
    if (s_q.rst_sync[1]) begin
      s_d.st    = ais_pkg::DV_RESET;
      s_d.ready = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '{rst_sync: 2'h0, sel_sync: 2'h0, ref_sync: 2'h0, clk_sync: 2'h0, st: ais_pkg::DV_RESET,
               cnt: 18'h0, soft_rst: 1'b0, ready: 1'b0, ref_mode: 1'b0, cfg: `AIS_CFG_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign READY    = s_q.ready;
  assign REF_MODE = s_q.ref_mode;
  assign CFG      = s_q.cfg;
endmodule

// File: hdl/ais_host.sv
// Host end: power-up sequence and serial programming
`include "ais_params.svh"
module ais_host #(
  parameter int PWR_WAIT_CYC = (`AIS_PWR_WAIT_NS + `AIS_CLK_NS - 1) / `AIS_CLK_NS,
  parameter int WAIT_CYC     = `AIS_CAL_CYCLES + `AIS_FUSE_CYCLES + 4
) (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RSTN,
  // Software port
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic [7:0]      RDATA,
  // Link
  ais_if.host             LNK
);
  localparam int REF_CYC = (`AIS_REF_SETUP_NS + `AIS_CLK_NS - 1) / `AIS_CLK_NS;
  localparam int RST_CYC = (`AIS_RST_PULSE_NS + `AIS_CLK_NS - 1) / `AIS_CLK_NS;

  // =====================================================
  // State
  typedef struct packed {
    ais_pkg::ais_host_state_e st;
    logic [18:0]              cnt;
    logic                     ref_lvl;
    logic                     ref_pin;
    logic                     rst_pin;
    logic                     clk_en;
    logic                     sel;
    ais_pkg::ais_byte_t       waddr;
    ais_pkg::ais_byte_t       wdata;
    logic                     go;
    ais_pkg::ais_byte_t       rdata;
  } ais_host_s;
  ais_host_s s_q, s_d;

  always_comb begin
    s_d     = s_q;
    s_d.sel = 1'b0;
    s_d.go  = 1'b0;
    if (WR) begin
      case (ADDR)
        `AIS_HOST_CTRL: begin
          s_d.ref_lvl = WDATA[1];
          s_d.go      = WDATA[0];
        end
        `AIS_HOST_WADDR: s_d.waddr = WDATA;
        `AIS_HOST_WDATA: s_d.wdata = WDATA;
        default: ;
      endcase
    end
    // Read data only moves on a read strobe
    if (RD) begin
      case (ADDR)
        `AIS_HOST_CTRL:  s_d.rdata = {6'h0, s_q.ref_lvl, 1'b0};
        `AIS_HOST_STAT:  s_d.rdata = {2'h0, s_q.st};
        `AIS_HOST_WADDR: s_d.rdata = s_q.waddr;
        `AIS_HOST_WDATA: s_d.rdata = s_q.wdata;
        default:         s_d.rdata = 8'h00;
      endcase
    end
    s_d.cnt = s_q.cnt + 19'h1;
    case (s_q.st)
      ais_pkg::HS_PWR: begin
        s_d.clk_en = 1'b1; // see R05
        if (s_q.cnt >= 19'(PWR_WAIT_CYC - 1)) begin
          s_d.ref_pin = s_q.ref_lvl; // see R03
          s_d.cnt     = '0;
          s_d.st      = ais_pkg::HS_REFSET;
        end
      end
      ais_pkg::HS_REFSET: begin
        if (s_q.cnt >= 19'(REF_CYC - 1)) begin // see R02
          s_d.rst_pin = 1'b1; // see R04
          s_d.cnt     = '0;
          s_d.st      = ais_pkg::HS_RSTHI;
        end
      end
      ais_pkg::HS_RSTHI: begin
        if (s_q.cnt >= 19'(RST_CYC - 1)) begin
          s_d.rst_pin = 1'b0; // see R01
          s_d.cnt     = '0;
          s_d.st      = ais_pkg::HS_WAIT;
        end
      end
      ais_pkg::HS_WAIT: begin
        // Margin over calibration covers the synchroniser and fuse load
        if (s_q.cnt >= 19'(WAIT_CYC - 1)) begin // see R08
          s_d.st = ais_pkg::HS_IDLE;
        end
      end
      ais_pkg::HS_IDLE: begin
        s_d.cnt = '0;
        if (s_q.go) begin
          s_d.sel = 1'b1;
          s_d.st  = ais_pkg::HS_WRITE;
        end
      end
      ais_pkg::HS_WRITE: begin
        // Select held for three cycles so the synchronised copy is seen
        s_d.sel = 1'b1;
        if (s_q.cnt >= 19'h2) begin
          s_d.sel = 1'b0;
          s_d.cnt = '0;
          s_d.st  = (s_q.waddr == `AIS_SOFT_RESET_CONTROL && s_q.wdata[`AIS_SOFT_RESET_BIT])
                    ? ais_pkg::HS_WAIT : ais_pkg::HS_IDLE; // see R08 R11
        end
      end
      default: s_d.st = ais_pkg::HS_PWR;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '{st: ais_pkg::HS_PWR, cnt: 19'h0, ref_lvl: 1'b0, ref_pin: 1'b0, rst_pin: 1'b0,
               clk_en: 1'b0, sel: 1'b0, waddr: 8'h00, wdata: 8'h00, go: 1'b0, rdata: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA                    = s_q.rdata;
  assign LNK.reset_pin            = s_q.rst_pin;
  assign LNK.reference_select_pin = s_q.ref_pin;
  assign LNK.sample_clk_en        = s_q.clk_en;
  assign LNK.serial_port_select   = s_q.sel;
  assign LNK.ser_addr             = s_q.waddr;
  assign LNK.ser_wdata            = s_q.wdata;
endmodule

// File: hdl/ais_if.sv
// Link between host controller and converter configuration logic
interface ais_if;
  logic       reset_pin;
  logic       reference_select_pin;
  logic       sample_clk_en;
  logic       serial_port_select;
  logic [7:0] ser_addr;
  logic [7:0] ser_wdata;
  modport host (output reset_pin, output reference_select_pin, output sample_clk_en,
                output serial_port_select, output ser_addr, output ser_wdata);
  modport dev  (input reset_pin, input reference_select_pin, input sample_clk_en,
                input serial_port_select, input ser_addr, input ser_wdata);
endinterface

// File: hdl/ais_params.svh
// Constants for the converter init and reset sequencer
// =====================================================
// Overview of operation
// R01 - Host pulses reset high at least 1 us
// R02 - Host sets reference pin before reset
// R03 - Host waits 2 ms before reference level
// R04 - 100 ns from reference level to reset
// R05 - Host runs sampling clock before reset
// R06 - Device loads defaults, then starts calibration
// R07 - Calibration lasts about 200000 sampling cycles
// R08 - Host waits 200000 cycles before programming
// R09 - Writing one to bit 0 soft-resets
// R10 - Device clears soft reset bit itself
// R11 - Host holds reset pin low meanwhile
// R12 - Device ignores serial writes while busy
`ifndef AIS_PARAMS_SVH
`define AIS_PARAMS_SVH
// =====================================================
// Register map
`define AIS_SOFT_RESET_CONTROL 8'h00
`define AIS_SOFT_RESET_BIT     0
`define AIS_CFG_REG            8'h01
`define AIS_CFG_RESET          8'h00
// Host command/status registers
`define AIS_HOST_CTRL          8'h00
`define AIS_HOST_STAT          8'h01
`define AIS_HOST_WADDR         8'h02
`define AIS_HOST_WDATA         8'h03
// =====================================================
// Timing
`define AIS_CLK_NS             8
`define AIS_PWR_WAIT_NS        2000000
`define AIS_REF_SETUP_NS       100
`define AIS_RST_PULSE_NS       1000
`define AIS_CAL_CYCLES         200000
`define AIS_FUSE_CYCLES        8
`endif

// File: hdl/ais_pkg.sv
// Types for the converter init and reset sequencer
package ais_pkg;
  typedef logic [7:0] ais_byte_t;
  typedef enum logic [3:0] {
    DV_RESET = 4'h1,
    DV_FUSE  = 4'h2,
    DV_CAL   = 4'h4,
    DV_READY = 4'h8
  } ais_dev_state_e;
  typedef enum logic [5:0] {
    HS_PWR    = 6'h01,
    HS_REFSET = 6'h02,
    HS_RSTHI  = 6'h04,
    HS_WAIT   = 6'h08,
    HS_IDLE   = 6'h10,
    HS_WRITE  = 6'h20
  } ais_host_state_e;
endpackage
